// ---- shared/fbm_pkg.sv ----
package fbm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_ARG = 8'h04;
  localparam logic [7:0] ADDR_WDATA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_FW_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FEATURES = 8'h14;
  localparam logic [7:0] ADDR_COMPLETE = 8'h18;
  localparam logic [7:0] ADDR_CONFIG = 8'h1C;
  localparam logic [7:0] ADDR_BLOCK_ADDR = 8'h20;

  // ----------------------------------------------------------------
  // Command identifiers
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_FEATURES = 16'h0041;
  localparam logic [15:0] CMD_FW_INFO = 16'h0100;
  localparam logic [15:0] CMD_START = 16'h0101;
  localparam logic [15:0] CMD_ABORT = 16'h0102;
  localparam logic [15:0] CMD_WRITE_LOCAL = 16'h0103;
  localparam logic [15:0] CMD_WRITE_EXT = 16'h0104;
  localparam logic [15:0] CMD_COMPLETE = 16'h0107;
  localparam logic [15:0] CMD_COPY = 16'h0108;
  localparam logic [15:0] CMD_RUN = 16'h0109;
  localparam logic [15:0] CMD_COMMIT = 16'h010A;

  // ----------------------------------------------------------------
  // Status codes, feature values, block sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_IDLE = 8'h00;
  localparam logic [7:0] ST_SUCCESS = 8'h01;
  localparam logic [7:0] ST_BUSY = 8'h80;
  localparam logic [7:0] ST_FAIL_UNKNOWN = 8'h41;
  localparam logic [7:0] ST_FAIL_STATE = 8'h42;
  localparam logic [7:0] ST_FAIL_PARAM = 8'h43;
  localparam logic [7:0] ST_FAIL_VALID = 8'h45;
  localparam logic [7:0] HEADER_LEN = 8'h70;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] LOCAL_BLOCK_MAX = 16'h0074;
  localparam logic [15:0] EXT_BLOCK_MAX = 16'h0800;
  localparam logic [7:0] WORD_BYTES = 8'h04;
  localparam int EXEC_NS = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam int EXEC_CYCLES = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NIB_RUN = 0;
  localparam int NIB_COMMIT = 1;
  localparam int NIB_INVALID = 2;
  localparam int CFG_EXT_SEL = 0;
  localparam int CFG_UPDATE_EN = 1;

  typedef enum logic [1:0] {
    FBM_BANK_A,
    FBM_BANK_B,
    FBM_BANK_FACTORY
  } fbm_bank_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fbm_bus_req_t;

  // Persistent per-bank image state
  typedef struct packed {
    logic [1:0] valid;
    logic [1:0] committed;
    fbm_bank_t running;
  } fbm_image_state_t;

endpackage

// ---- rtl/fbm_top.sv ----
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module fbm_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire fbm_pkg::fbm_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // Persistent store image, loaded at power-up
  input wire fbm_pkg::fbm_image_state_t nv_state_in,
  output fbm_pkg::fbm_image_state_t nv_state_out,
  // Completion flag, one-cycle pulse
  output logic cmd_done
);
  import fbm_pkg::*;

  typedef enum logic [1:0] {
    FBM_ST_IDLE,
    FBM_ST_EXEC,
    FBM_ST_REPORT
  } fbm_fsm_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_write_cmd(input logic [15:0] id);
    return (id == CMD_WRITE_LOCAL) || (id == CMD_WRITE_EXT);
  endfunction

  function automatic logic [3:0] nibble(input fbm_image_state_t s,
                                        input logic b);
    logic [3:0] n;
    n = 4'h0;
    n[NIB_RUN] = (s.running == fbm_bank_t'({1'b0, b}));
    n[NIB_COMMIT] = s.committed[b];
    n[NIB_INVALID] = ~s.valid[b];
    return n;
  endfunction

  fbm_fsm_t state_reg;
  fbm_image_state_t img_reg;
  logic loaded_reg;
  logic [15:0] cmd_reg;
  logic [31:0] arg_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [3:0] exec_cnt_reg;
  logic dl_active_reg;
  logic dl_bank_reg;
  logic dl_ok_reg;
  logic [31:0] blk_addr_reg;
  logic [1:0] cfg_reg;
  logic done_reg;
  logic [31:0] rdata_reg;
  logic [31:0] wdata_reg;
  logic [15:0] blk_max;
  logic cmd_go;
  logic [7:0] fw_status;

  assign cmd_go = bus_req.wr && (bus_req.addr == ADDR_COMMAND)
                  && (state_reg == FBM_ST_IDLE);
  assign blk_max = cfg_reg[CFG_EXT_SEL] ? EXT_BLOCK_MAX : LOCAL_BLOCK_MAX;
  assign fw_status = {nibble(img_reg, 1'b1), nibble(img_reg, 1'b0)};

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // Command capture and execution pacing; busy commands are dropped
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= FBM_ST_IDLE;
      cmd_reg <= 16'h0000;
      exec_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        FBM_ST_IDLE: begin
          // Only an idle sequencer takes a command; busy writes are lost
          if (cmd_go) begin
            cmd_reg <= bus_req.wdata[15:0];
            exec_cnt_reg <= 4'(EXEC_CYCLES);
            state_reg <= FBM_ST_EXEC;
          end
        end
        FBM_ST_EXEC: begin
          // Fixed pacing stands in for the real execution time
          if (exec_cnt_reg <= 4'h1) begin
            state_reg <= FBM_ST_REPORT;
          end else begin
            exec_cnt_reg <= exec_cnt_reg - 4'h1;
          end
        end
        FBM_ST_REPORT: state_reg <= FBM_ST_IDLE;
        default: state_reg <= FBM_ST_IDLE;
      endcase
    end
  end

  // Argument and data words, latched whenever written
  // Data word is only held for readback; no image store sits behind it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      arg_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      cfg_reg <= 2'b10;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_ARG) arg_reg <= bus_req.wdata;
      if (bus_req.addr == ADDR_WDATA) wdata_reg <= bus_req.wdata;
      if (bus_req.addr == ADDR_CONFIG) cfg_reg <= bus_req.wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Result of the current command
  // ----------------------------------------------------------------
  // Verdict settles during execution; a refusal changes no state, except that a complete failing validation ends the session
  always_comb begin
    status_next = ST_SUCCESS;
    case (cmd_reg)
      CMD_FEATURES, CMD_FW_INFO: status_next = ST_SUCCESS;
      CMD_START: begin
        if (!cfg_reg[CFG_UPDATE_EN] || dl_active_reg) begin
          status_next = ST_FAIL_STATE;
        end else if (arg_reg[0] == img_reg.running[0]
                     && img_reg.running != FBM_BANK_FACTORY) begin
          status_next = ST_FAIL_PARAM; // Never erase the running bank
        end
      end
      CMD_WRITE_LOCAL, CMD_WRITE_EXT: begin
        if (!dl_active_reg) begin
          status_next = ST_FAIL_STATE;
        end else if ((cmd_reg == CMD_WRITE_EXT) != cfg_reg[CFG_EXT_SEL]
                     || arg_reg[15:0] > blk_max) begin
          status_next = ST_FAIL_PARAM;
        end
      end
      CMD_ABORT: begin
        if (!dl_active_reg) status_next = ST_FAIL_STATE;
      end
      CMD_COMPLETE: begin
        if (!dl_active_reg) begin
          status_next = ST_FAIL_STATE;
        end else if (!dl_ok_reg) begin
          status_next = ST_FAIL_VALID;
        end
      end
      CMD_COPY: begin
        if (dl_active_reg || !img_reg.valid[arg_reg[0]]) begin
          status_next = ST_FAIL_STATE;
        end
      end
      CMD_RUN, CMD_COMMIT: begin
        if (arg_reg[0] ? !img_reg.valid[1] : !img_reg.valid[0]) begin
          status_next = ST_FAIL_STATE;
        end
      end
      default: status_next = ST_FAIL_UNKNOWN;
    endcase
  end

  // Status is written one cycle before the completion pulse
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      status_reg <= ST_IDLE;
      done_reg <= 1'b0;
    end else begin
      // Flag trails the status by one edge so software never sees it early
      done_reg <= (state_reg == FBM_ST_REPORT);
      if (cmd_go) begin
        status_reg <= ST_BUSY;
      end else if (state_reg == FBM_ST_EXEC && exec_cnt_reg <= 4'h1) begin
        status_reg <= status_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Download session
  // ----------------------------------------------------------------
  // Sessions end only via complete or abort, either outcome
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dl_active_reg <= 1'b0;
      dl_bank_reg <= 1'b0;
      dl_ok_reg <= 1'b0;
      blk_addr_reg <= 32'h0000_0000;
    end else if (state_reg == FBM_ST_REPORT
                 && status_reg == ST_SUCCESS) begin
      case (cmd_reg)
        CMD_START: begin
          dl_active_reg <= 1'b1;
          dl_bank_reg <= arg_reg[0];
          dl_ok_reg <= 1'b0;
          blk_addr_reg <= 32'h0000_0000;
        end
        CMD_ABORT, CMD_COMPLETE: dl_active_reg <= 1'b0;
        default: begin
          // A block counts as good only with a zero upper argument half
          if (is_write_cmd(cmd_reg)) begin
            dl_ok_reg <= dl_ok_reg || (arg_reg[31:16] == 16'h0000);
            blk_addr_reg <= blk_addr_reg + {16'h0000, arg_reg[15:0]};
          end
        end
      endcase
    end else if (state_reg == FBM_ST_REPORT && cmd_reg == CMD_COMPLETE
                 && status_reg == ST_FAIL_VALID) begin
      dl_active_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bank administration
  // ----------------------------------------------------------------
  // Power-up picks the committed bank; persistent copy sampled on release
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      img_reg <= '0;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      img_reg <= nv_state_in;
      if (nv_state_in.committed[1] && nv_state_in.valid[1]) begin
        img_reg.running <= FBM_BANK_B;
      end else if (nv_state_in.committed[0] && nv_state_in.valid[0]) begin
        img_reg.running <= FBM_BANK_A;
      end else begin
        // A committed bank that is not valid falls back to factory
        img_reg.running <= FBM_BANK_FACTORY;
      end
    end else if (state_reg == FBM_ST_REPORT
                 && status_reg == ST_SUCCESS) begin
      case (cmd_reg)
        CMD_START: img_reg.valid[arg_reg[0]] <= 1'b0;
        CMD_COMPLETE: img_reg.valid[dl_bank_reg] <= 1'b1;
        CMD_COPY: img_reg.valid[~arg_reg[0]] <= 1'b1;
        CMD_RUN: img_reg.running <= fbm_bank_t'({1'b0, arg_reg[0]});
        CMD_COMMIT: begin
          img_reg.committed <= arg_reg[0] ? 2'b10 : 2'b01;
        end
        default: img_reg <= img_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  // Data live for one cycle only, so a stale word never lingers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_COMMAND: rdata_reg <= {16'h0000, cmd_reg};
        ADDR_ARG: rdata_reg <= arg_reg;
        ADDR_WDATA: rdata_reg <= wdata_reg;
        ADDR_STATUS: rdata_reg <= {24'h00_0000, status_reg};
        ADDR_FW_STATUS: rdata_reg <= {24'h00_0000, fw_status};
        ADDR_FEATURES: begin
          // Top bit replaces the size's top bit, which is always zero
          rdata_reg <= {cfg_reg[CFG_UPDATE_EN], EXT_BLOCK_MAX[14:0],
                        ERASED_BYTE, HEADER_LEN};
        end
        ADDR_COMPLETE: rdata_reg <= {31'h0000_0000, dl_active_reg};
        ADDR_CONFIG: rdata_reg <= {30'h0000_0000, cfg_reg};
        ADDR_BLOCK_ADDR: rdata_reg <= blk_addr_reg;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Every output comes straight from its register
  assign bus_rdata = rdata_reg;
  assign cmd_done = done_reg;
  assign nv_state_out = img_reg;
endmodule

// ---- verification/fbm_monitor.sv ----
`timescale 1ns/1ps
// ----
// Port checker
// ----
module fbm_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire fbm_pkg::fbm_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  // Image state and completion
  input wire fbm_pkg::fbm_image_state_t nv_state_in,
  input wire fbm_pkg::fbm_image_state_t nv_state_out,
  input wire logic cmd_done
);
  import fbm_pkg::*;
  logic cmd_wr;
  logic st_rd;
  logic fw_rd;
  logic [2:0] busy_reg;
  logic [1:0] up_reg;
  // Bus decodes seen by the checks
  assign cmd_wr = bus_req.wr && bus_req.addr == ADDR_COMMAND;
  assign st_rd = bus_req.rd && bus_req.addr == ADDR_STATUS;
  assign fw_rd = bus_req.rd && bus_req.addr == ADDR_FW_STATUS;
  // Command window, one cycle longer than the pulse for slack
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) busy_reg <= 3'h0;
    else if (cmd_wr && busy_reg == 3'h0) busy_reg <= 3'h7;
    else if (busy_reg != 3'h0) busy_reg <= busy_reg - 3'h1;
  end
  // Edges since release; state loads on the first
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 32'h0000_0000)
    else $error("read data not zero");
  done_pulse_a: assert property (cmd_done |=> !cmd_done)
    else $error("completion pulse too long");
  done_cause_a: assert property (cmd_done |-> $past(cmd_wr, 6))
    else $error("completion without command");
  done_time_a: assert property (cmd_wr && busy_reg == 3'h0 |=>
    !cmd_done [*5] ##1 cmd_done) else $error("completion late");
  busy_read_a: assert property (cmd_wr && busy_reg == 3'h0 ##2 st_rd
    |=> bus_rdata[7:0] == ST_BUSY) else $error("status not busy");
  final_read_a: assert property (cmd_done && st_rd |=>
    bus_rdata[7:0] != ST_BUSY) else $error("status busy at completion");
  nv_quiet_a: assert property (up_reg == 2'h3 && $changed(nv_state_out)
    |-> busy_reg != 3'h0) else $error("bank state moved unbidden");
  commit_one_a: assert property (up_reg == 2'h3 |->
    $onehot(nv_state_out.committed)) else $error("commit not one bank");
  nibble_a_a: assert property (fw_rd |=> bus_rdata[2:0] ==
    {~$past(nv_state_out.valid[0]), $past(nv_state_out.committed[0]),
    $past(nv_state_out.running) == FBM_BANK_A}) else $error("bank A nibble");
endmodule
bind fbm_top fbm_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .nv_state_in(nv_state_in),
  .nv_state_out(nv_state_out), .cmd_done(cmd_done));

// ---- verification/fbm_host.sv ----
`timescale 1ns/1ps
// ----
// Host controller model
// ----
module fbm_host (
  // Clock
  input wire logic sys_clk,
  // Register port
  output fbm_pkg::fbm_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  // Completion
  input wire logic cmd_done
);
  import fbm_pkg::*;
  initial bus_req = '0;
  // One bus cycle; every field changes together after an edge
  task op(input logic [7:0] a, input logic [31:0] d, input logic w,
    input logic r);
    bus_req <= '{a, d, w, r};
    @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    op(a, d, 1'h1, 1'h0);
    op(a, d, 1'h0, 1'h0);
  endtask
  // Answer caught at the next edge, before that edge clears it
  task rd(input logic [7:0] a, output logic [31:0] d);
    op(a, 32'h0000_0000, 1'h0, 1'h1);
    op(a, 32'h0000_0000, 1'h0, 1'h0);
    d = bus_rdata;
  endtask
  // Argument before id; nothing new until the completion pulse or 20 status polls
  task cmd(input logic [15:0] id, input logic [31:0] arg,
    output logic [7:0] st);
    int n;
    logic [31:0] v;
    logic seen;
    op(ADDR_ARG, arg, 1'h1, 1'h0);
    op(ADDR_COMMAND, {16'h0000, id}, 1'h1, 1'h0);
    n = 0;
    do begin
      op(ADDR_STATUS, 32'h0000_0000, 1'h0, 1'h1);
      n++;
    end while (cmd_done !== 1'h1 && n < 20);
    seen = (cmd_done === 1'h1);
    rd(ADDR_STATUS, v);
    st = v[7:0];
    // A missing pulse reports idle, which no scenario ever expects
    if (!seen) st = ST_IDLE;
  endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import fbm_pkg::*;
  logic sys_clk;
  logic reset;
  fbm_bus_req_t bus_req;
  logic [31:0] bus_rdata;
  fbm_image_state_t nv_state_in;
  fbm_image_state_t nv_state_out;
  logic cmd_done;
  int miscompares;
  int checks_done;
  logic [31:0] v;
  logic [7:0] st;
  localparam logic [31:0] ARG_LOC = {16'h0000, LOCAL_BLOCK_MAX};
  localparam logic [31:0] ARG_EXT = {16'h0000, EXT_BLOCK_MAX};
  fbm_top i_fbm_top (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .nv_state_in(nv_state_in),
    .nv_state_out(nv_state_out), .cmd_done(cmd_done));
  fbm_host u_host (.sys_clk(sys_clk), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .cmd_done(cmd_done));
  // ----
  // Clock and shared tasks
  // ----
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Stored bank state is presented while reset is held
  task rst(input fbm_image_state_t nv);
    reset <= 1'h1;
    nv_state_in <= nv;
    repeat (10) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task run(input logic [15:0] id, input logic [31:0] arg,
    input logic [7:0] exp);
    u_host.cmd(id, arg, st);
    chk({24'h00_0000, st}, {24'h00_0000, exp});
  endtask
  task fw(input logic [7:0] exp);
    u_host.rd(ADDR_FW_STATUS, v);
    chk({24'h00_0000, v[7:0]}, {24'h00_0000, exp});
  endtask
  task reg_rd(input logic [7:0] a, input logic [31:0] exp);
    u_host.rd(a, v);
    chk(v, exp);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_boot;
    rst('{2'h3, 2'h1, FBM_BANK_A});
    fw(8'h03);
    reg_rd(ADDR_FEATURES, 32'h8800_FF70);
    reg_rd(ADDR_CONFIG, 32'h0000_0002);
    reg_rd(8'h3C, 32'h0000_0000);
    run(CMD_FEATURES, 32'h0000_0000, ST_SUCCESS);
    run(CMD_FW_INFO, 32'h0000_0000, ST_SUCCESS);
    run(16'h0077, 32'h0000_0000, ST_FAIL_UNKNOWN);
    u_host.wr(ADDR_CONFIG, 32'h0000_0000);
    reg_rd(ADDR_FEATURES, 32'h0800_FF70);
    run(CMD_START, 32'h0000_0001, ST_FAIL_STATE);
    u_host.wr(ADDR_CONFIG, 32'h0000_0002);
    run(CMD_ABORT, 32'h0000_0001, ST_FAIL_STATE);
    run(CMD_COMPLETE, 32'h0000_0001, ST_FAIL_STATE);
    $display("boot done");
  endtask
  task t_load;
    run(CMD_WRITE_LOCAL, ARG_LOC, ST_FAIL_STATE);
    run(CMD_START, 32'h0000_0000, ST_FAIL_PARAM);
    run(CMD_START, 32'h0000_0001, ST_SUCCESS);
    fw(8'h43);
    run(CMD_START, 32'h0000_0001, ST_FAIL_STATE);
    run(CMD_RUN, 32'h0000_0001, ST_FAIL_STATE);
    run(CMD_COMMIT, 32'h0000_0001, ST_FAIL_STATE);
    run(CMD_WRITE_EXT, ARG_LOC, ST_FAIL_PARAM);
    run(CMD_WRITE_LOCAL, ARG_LOC + 32'h1, ST_FAIL_PARAM);
    run(CMD_WRITE_LOCAL, ARG_LOC, ST_SUCCESS);
    reg_rd(ADDR_COMMAND, {16'h0000, CMD_WRITE_LOCAL});
    reg_rd(ADDR_ARG, ARG_LOC);
    reg_rd(ADDR_BLOCK_ADDR, ARG_LOC);
    reg_rd(ADDR_COMPLETE, 32'h0000_0001);
    fw(8'h43);
    run(CMD_COMPLETE, 32'h0000_0001, ST_SUCCESS);
    reg_rd(ADDR_COMPLETE, 32'h0000_0000);
    fw(8'h03);
    // Image words travel as binary, never as text
    u_host.wr(ADDR_WDATA, 32'h5A5A_A5A5);
    reg_rd(ADDR_WDATA, 32'h5A5A_A5A5);
    $display("load done");
  endtask
  // Failed and abandoned sessions, then a clean one on the wide variant
  task t_retry;
    run(CMD_START, 32'h0000_0001, ST_SUCCESS);
    run(CMD_WRITE_LOCAL, {16'h0001, LOCAL_BLOCK_MAX}, ST_SUCCESS);
    run(CMD_COMPLETE, 32'h0000_0001, ST_FAIL_VALID);
    fw(8'h43);
    run(CMD_COPY, 32'h0000_0001, ST_FAIL_STATE);
    run(CMD_COPY, 32'h0000_0000, ST_SUCCESS);
    fw(8'h03);
    u_host.wr(ADDR_CONFIG, 32'h0000_0003);
    run(CMD_START, 32'h0000_0001, ST_SUCCESS);
    run(CMD_COPY, 32'h0000_0000, ST_FAIL_STATE);
    run(CMD_WRITE_EXT, ARG_EXT, ST_SUCCESS);
    run(CMD_ABORT, 32'h0000_0001, ST_SUCCESS);
    run(CMD_WRITE_EXT, ARG_EXT, ST_FAIL_STATE);
    fw(8'h43);
    run(CMD_START, 32'h0000_0001, ST_SUCCESS);
    // Erased blocks are skipped, so one block stands for the image
    run(CMD_WRITE_EXT, ARG_EXT, ST_SUCCESS);
    reg_rd(ADDR_BLOCK_ADDR, ARG_EXT);
    run(CMD_COMPLETE, 32'h0000_0001, ST_SUCCESS);
    fw(8'h03);
    $display("retry done");
  endtask
  task t_swap;
    run(CMD_RUN, 32'h0000_0001, ST_SUCCESS);
    fw(8'h12);
    run(CMD_COMMIT, 32'h0000_0001, ST_SUCCESS);
    fw(8'h30);
    run(CMD_RUN, 32'h0000_0000, ST_SUCCESS);
    fw(8'h21);
    rst(nv_state_out);
    fw(8'h30);
    rst('{2'h0, 2'h1, FBM_BANK_A});
    fw(8'h46);
    $display("swap done");
  endtask
  // Watchdog well past the whole sequence
  initial begin
    #50000;
    miscompares++;
    finish_test;
  end
  initial begin
    miscompares = 0;
    checks_done = 0;
    reset = 1'h1;
    nv_state_in = '0;
    t_boot;
    t_load;
    t_retry;
    t_swap;
    finish_test;
  end
endmodule
